/* sqf_pkg.sv */
// Shared types and constants for the sample queue status flag logic
package sqf_pkg;
  // Status word layout, high bit first
  typedef struct packed {
    logic [1:0] rsvd;
    logic read_err;
    logic above;
    logic below;
    logic overrun;
    logic watermark;
    logic empty;
  } sqf_status_t;

  // Limit value register, upper limit in the high field
  typedef struct packed {
    logic [11:0] upper;
    logic [11:0] lower;
  } sqf_limits_t;

  typedef enum logic {
    QM_WATERMARK,
    QM_STREAM
  } sqf_mode_t;

  localparam int unsigned LIMIT_W = 12;
  localparam int unsigned FLAG_N = 6;
  localparam int unsigned STATUS_EMPTY_BIT = 0;
  localparam int unsigned STATUS_WMARK_BIT = 1;
  localparam int unsigned STATUS_OVERRUN_BIT = 2;
  localparam int unsigned STATUS_BELOW_BIT = 3;
  localparam int unsigned STATUS_ABOVE_BIT = 4;
  localparam int unsigned STATUS_RDERR_BIT = 5;
  localparam logic [7:0] STATUS_RESET = 8'h01;
  localparam logic [11:0] UPPER_LIMIT_RESET = 12'hFFF;
  localparam logic [11:0] LOWER_LIMIT_RESET = 12'h000;
  localparam logic [23:0] LIMITS_RESET = {UPPER_LIMIT_RESET, LOWER_LIMIT_RESET};
endpackage : sqf_pkg

/* sqf_queue_flags.sv */
// Occupancy tracking and status flags for the conversion-result queue
`timescale 1ns/100ps
`default_nettype none
module sqf_queue_flags #(
  parameter int unsigned DEPTH = 256,
  parameter int unsigned CHANNELS = 16,
  parameter int unsigned DATA_W = 16,
  parameter int unsigned CNT_W = $clog2(DEPTH + 1)
) (
  input wire logic I_REF_CLK,
  input wire logic I_NRST,
  input wire logic I_QUEUE_EN,
  input wire sqf_pkg::sqf_mode_t I_QUEUE_MODE,
  input wire logic [CNT_W-1:0] I_WATERMARK,
  input wire logic I_CLEAR,
  input wire logic [CHANNELS-1:0] I_CHAN_LIMIT_EN,
  input wire logic I_LIMIT_WR,
  input wire sqf_pkg::sqf_limits_t I_LIMIT_WDATA,
  input wire logic I_WR_VALID,
  input wire logic [DATA_W-1:0] I_WR_DATA,
  input wire logic [$clog2(CHANNELS)-1:0] I_WR_CHAN,
  input wire logic I_RD_REQ,
  output sqf_pkg::sqf_status_t O_STATUS,
  output logic [sqf_pkg::FLAG_N-1:0] O_FLAG_IRQ,
  output sqf_pkg::sqf_limits_t O_LIMITS,
  output logic [CNT_W-1:0] O_COUNT,
  output logic O_WR_STORED,
  output logic O_WR_DISCARD,
  output logic O_DROP_OLDEST,
  output logic O_RD_GRANT,
  output logic O_RD_REFUSED
);
  import sqf_pkg::*;

  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] ONE_C = CNT_W'(1);

  sqf_status_t status_q, status_d;
  sqf_limits_t limits_q;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [FLAG_N-1:0] irq_q;
  logic wr, rd, full, rd_ok, coll, discard, drop, store, flush;
  logic [LIMIT_W-1:0] sample;
  logic limit_chk;

  // Event decode; a disabled queue ignores both sides
  always_comb begin
    wr = I_QUEUE_EN & I_WR_VALID & ~I_CLEAR;
    rd = I_QUEUE_EN & I_RD_REQ & ~I_CLEAR;
    flush = ~I_QUEUE_EN | I_CLEAR;
    full = (cnt_q == DEPTH_C);
    coll = rd & wr;
    rd_ok = rd & ~wr & (cnt_q != '0);
    discard = wr & full & (I_QUEUE_MODE == QM_WATERMARK);
    drop = wr & full & (I_QUEUE_MODE == QM_STREAM);
    store = wr & ~discard;
    sample = I_WR_DATA[DATA_W-1 -: LIMIT_W];
    limit_chk = store & I_CHAN_LIMIT_EN[I_WR_CHAN];
  end

  // Next occupancy; a stream-mode overwrite keeps the count at full
  always_comb begin
    cnt_d = cnt_q;
    if (flush) begin
      cnt_d = '0;
    end else if (store && !full) begin
      cnt_d = cnt_q + ONE_C;
    end else if (rd_ok) begin
      cnt_d = cnt_q - ONE_C;
    end
  end

  // Next flags; sets are applied after the empty clear so a set wins
  always_comb begin
    status_d = status_q;
    status_d.rsvd = 2'b00;
    status_d.empty = (cnt_d == '0);
    status_d.watermark = (cnt_d >= I_WATERMARK);
    if (cnt_d == '0) begin
      status_d.below = 1'b0;
      status_d.above = 1'b0;
      status_d.overrun = 1'b0;
      status_d.read_err = 1'b0;
    end
    if (rd_ok) begin
      status_d.read_err = 1'b0;
    end
    if (discard || drop) begin
      status_d.overrun = 1'b1;
    end
    if (limit_chk && sample <= limits_q.lower) begin
      status_d.below = 1'b1;
    end
    if (limit_chk && sample >= limits_q.upper) begin
      status_d.above = 1'b1;
    end
    if (coll) begin
      status_d.read_err = 1'b1;
    end
  end

  // Status and occupancy registers, moved by queue events and, for the watermark flag, by I_WATERMARK
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      status_q <= sqf_status_t'(STATUS_RESET);
      cnt_q <= '0;
    end else begin
      status_q <= status_d;
      cnt_q <= cnt_d;
    end
  end

  // Limit values; meant to be static while results are queued
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      limits_q <= sqf_limits_t'(LIMITS_RESET);
    end else if (I_LIMIT_WR) begin
      limits_q <= I_LIMIT_WDATA;
    end
  end

  // Interrupt lines copy next flags so they stand in step with the word
  generate
    for (genvar g = 0; g < FLAG_N; g++) begin : g_irq
      always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          irq_q[g] <= STATUS_RESET[g];
        end else begin
          irq_q[g] <= status_d[g];
        end
      end
    end
  endgenerate

  // One-cycle event strobes for the storage and read side
  always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WR_STORED <= 1'b0;
      O_WR_DISCARD <= 1'b0;
      O_DROP_OLDEST <= 1'b0;
      O_RD_GRANT <= 1'b0;
      O_RD_REFUSED <= 1'b0;
    end else begin
      O_WR_STORED <= store;
      O_WR_DISCARD <= discard;
      O_DROP_OLDEST <= drop;
      O_RD_GRANT <= rd_ok;
      O_RD_REFUSED <= coll;
    end
  end

  assign O_STATUS = status_q;
  assign O_FLAG_IRQ = irq_q;
  assign O_LIMITS = limits_q;
  assign O_COUNT = cnt_q;

  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!I_NRST);

  sequence s_full_write;
    I_QUEUE_EN && !I_CLEAR && I_WR_VALID && cnt_q == DEPTH_C;
  endsequence

  sequence s_wm_overflow;
    s_full_write ##0 I_QUEUE_MODE == QM_WATERMARK;
  endsequence

  sequence s_stream_overflow;
    s_full_write ##0 I_QUEUE_MODE == QM_STREAM;
  endsequence

  AST_EMPTY_MATCHES_COUNT: assert property (
    O_STATUS.empty == (O_COUNT == '0))
    else $error("empty flag disagrees with occupancy");

  AST_DISABLED_EMPTY: assert property (
    !I_QUEUE_EN |=> O_STATUS.empty && O_COUNT == '0 && !O_STATUS.overrun)
    else $error("disabled queue not empty");

  AST_WM_DISCARD: assert property (
    s_wm_overflow |=> O_STATUS.overrun && O_WR_DISCARD && O_COUNT == DEPTH_C && !O_WR_STORED)
    else $error("watermark overflow not discarded");

  AST_STREAM_DROP: assert property (
    s_stream_overflow |=> O_STATUS.overrun && O_DROP_OLDEST && O_WR_STORED && O_COUNT == DEPTH_C)
    else $error("stream overflow did not drop oldest");

  AST_EMPTY_CLEARS: assert property (
    O_STATUS.empty |-> !O_STATUS.overrun && !O_STATUS.below && !O_STATUS.above)
    else $error("flag left set on empty queue");

  AST_WATERMARK: assert property (
    O_STATUS.watermark == (O_COUNT >= $past(I_WATERMARK)))
    else $error("fill-level flag wrong");

  AST_IRQ_FOLLOWS: assert property (
    O_FLAG_IRQ == O_STATUS[FLAG_N-1:0])
    else $error("interrupt out of step with flag");

  AST_COLLISION: assert property (
    I_QUEUE_EN && !I_CLEAR && I_RD_REQ && I_WR_VALID |=> O_STATUS.read_err && O_RD_REFUSED
      && !O_RD_GRANT)
    else $error("read collision not flagged");

  AST_BELOW_SET: assert property (
    I_QUEUE_EN && !I_CLEAR && I_WR_VALID && cnt_q != DEPTH_C && I_CHAN_LIMIT_EN[I_WR_CHAN]
      && I_WR_DATA[DATA_W-1 -: LIMIT_W] <= O_LIMITS.lower && !I_LIMIT_WR |=> O_STATUS.below)
    else $error("below-limit flag not set");

  AST_LAST_READ_EMPTY: assert property (
    I_QUEUE_EN && !I_CLEAR && I_RD_REQ && !I_WR_VALID && O_COUNT == ONE_C
      |=> O_STATUS.empty && O_RD_GRANT)
    else $error("last read did not empty queue");
endmodule : sqf_queue_flags
`default_nettype wire

/* sqf_host_model.sv */
// Host model that issues queue reads toward the flag block
`timescale 1ns/100ps
`default_nettype none
module sqf_host_model (
  input wire logic i_rd_go,
  output logic o_rd_req
);
  // Pass-through keeps the read on the bench's falling-edge timing
  assign o_rd_req = i_rd_go;
endmodule : sqf_host_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for the queue status flag block
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sqf_pkg::*;
  logic clk;
  logic nrst;
  logic en;
  sqf_mode_t mode;
  logic [2:0] wm;
  logic clr;
  logic [15:0] chen;
  logic lwr;
  sqf_limits_t lwd;
  logic wv;
  logic [15:0] wd;
  logic [3:0] ch;
  logic rd_go;
  logic rd_req;
  sqf_status_t st;
  logic [5:0] irq;
  sqf_limits_t lim;
  logic [2:0] cnt;
  logic sto;
  logic dis;
  logic drp;
  logic gnt;
  logic refd;
  int n_errors;
  int n_tests;
  // Small depth so overflow is reached in a few writes
  sqf_queue_flags #(.DEPTH(4)) dut_u (.I_REF_CLK(clk), .I_NRST(nrst), .I_QUEUE_EN(en),
    .I_QUEUE_MODE(mode), .I_WATERMARK(wm), .I_CLEAR(clr), .I_CHAN_LIMIT_EN(chen),
    .I_LIMIT_WR(lwr), .I_LIMIT_WDATA(lwd), .I_WR_VALID(wv), .I_WR_DATA(wd),
    .I_WR_CHAN(ch), .I_RD_REQ(rd_req), .O_STATUS(st), .O_FLAG_IRQ(irq), .O_LIMITS(lim),
    .O_COUNT(cnt), .O_WR_STORED(sto), .O_WR_DISCARD(dis), .O_DROP_OLDEST(drp),
    .O_RD_GRANT(gnt), .O_RD_REFUSED(refd));
  sqf_host_model host_u (.i_rd_go(rd_go), .o_rd_req(rd_req));
  always #2 clk = ~clk;
  task automatic end_sim;
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_sim
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  // One event cycle; strobes are still high at the following falling edge
  task automatic ev(input logic w, input logic r, input logic [15:0] d);
    @(negedge clk);
    wv = w;
    rd_go = r;
    wd = d;
    @(negedge clk);
    wv = 0;
    rd_go = 0;
  endtask : ev
  task automatic t_reset;
    chk(st, 8'h01);
    chk(irq, 6'h01);
    chk(lim, 24'hFF_F000);
    chk(cnt, 3'h0);
  endtask : t_reset
  task automatic t_limits;
    @(negedge clk);
    lwr = 1;
    lwd = 24'hE0_0100;
    @(negedge clk);
    lwr = 0;
    chk(lim, 24'hE0_0100);
    ev(1, 0, 16'h0F00);
    chk(st, 8'h08);
    chk(irq, 6'h08);
    ev(1, 0, 16'hE000);
    chk(st, 8'h1A);
    chk(sto, 1'b1);
  endtask : t_limits
  task automatic t_overrun;
    ev(1, 0, 16'h5000);
    ev(1, 0, 16'h5000);
    ev(1, 0, 16'h5000);
    chk(dis, 1'b1);
    chk(st, 8'h1E);
    chk(irq, 6'h1E);
    chk(cnt, 3'h4);
    repeat (3) ev(0, 1, 16'h0000);
    chk(st, 8'h1C);
    ev(0, 1, 16'h0000);
    chk(gnt, 1'b1);
    chk(st, 8'h01);
  endtask : t_overrun
  task automatic t_collide;
    ev(1, 1, 16'h5000);
    chk(refd, 1'b1);
    chk(st, 8'h20);
    chk(cnt, 3'h1);
    ev(0, 1, 16'h0000);
    chk(st, 8'h01);
  endtask : t_collide
  task automatic t_stream;
    mode = QM_STREAM;
    repeat (5) ev(1, 0, 16'h5000);
    chk(drp, 1'b1);
    chk(sto, 1'b1);
    chk(st, 8'h06);
    chk(cnt, 3'h4);
    @(negedge clk);
    clr = 1;
    @(negedge clk);
    clr = 0;
    chk(st, 8'h01);
    en = 0;
    ev(1, 0, 16'h5000);
    chk(st, 8'h01);
    chk(cnt, 3'h0);
  endtask : t_stream
  // Limit checks honour the per-channel enable
  task automatic t_chan;
    en = 1;
    mode = QM_WATERMARK;
    ch = 4'h1;
    ev(1, 0, 16'h0000);
    chk(st, 8'h00);
    ch = 4'h0;
    ev(1, 0, 16'hFFF0);
    chk(st, 8'h12);
    chk(irq, 6'h12);
  endtask : t_chan
  // Reset in mid-run restores status, limits and count, then a write is taken at the second rising edge after release
  task automatic t_midreset;
    @(negedge clk);
    nrst = 0;
    @(negedge clk);
    chk(st, 8'h01);
    chk(lim, 24'hFF_F000);
    chk(cnt, 3'h0);
    nrst = 1;
    ev(1, 0, 16'h5000);
    chk(st, 8'h00);
    chk(cnt, 3'h1);
    chk(irq, 6'h00);
  endtask : t_midreset
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_sim();
  end
  initial begin
    clk = 0;
    nrst = 0;
    en = 1;
    mode = QM_WATERMARK;
    wm = 3'h2;
    clr = 0;
    chen = 16'h0001;
    lwr = 0;
    lwd = 24'h00_0000;
    wv = 0;
    wd = 16'h0000;
    ch = 4'h0;
    rd_go = 0;
    n_errors = 0;
    n_tests = 0;
    repeat (16) @(negedge clk);
    nrst = 1;
    t_reset();
    t_limits();
    t_overrun();
    t_collide();
    t_stream();
    t_chan();
    t_midreset();
    end_sim();
  end
endmodule : testbench
`default_nettype wire
